// ### dscg_pkg.sv
// Package: register map, field layout and types of the deep-sleep clock gating block
package dscg_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [11:0] DEEP_SLEEP_CLOCK_GATE_0_OFS = 12'h120;
   localparam logic [11:0] RUN_CLOCK_GATE_0_OFS = 12'h100;
   localparam logic [11:0] SLEEP_CLOCK_GATE_0_OFS = 12'h110;
   localparam logic [11:0] RUN_CLOCK_CONFIG_OFS = 12'h060;
   localparam logic [11:0] MODE_CTRL_OFS = 12'h180;
   localparam logic [11:0] IRQ_STATUS_OFS = 12'h184;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h188;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ADC0_BIT = 16;
   localparam int HIBERNATION_BIT = 6;
   localparam int WATCHDOG_BIT = 3;
   localparam int AUTO_CLOCK_GATING_BIT = 27;
   localparam int NUM_GATES = 3;

   // ----------------------------------------
   // Masks and reset values
   // ----------------------------------------
   localparam logic [31:0] GATE_WRITABLE_MASK = 32'h0001_0048;
   localparam logic [31:0] GATE_RESET = 32'h0000_0040;
   localparam logic [31:0] RUN_CONFIG_WRITABLE_MASK = 32'h0800_0000;
   localparam logic [31:0] RUN_CONFIG_RESET = 32'h0000_0000;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   // Bit of each gate within the gating registers, gate index 0..2
   localparam int GATE_POS [NUM_GATES] = '{ADC0_BIT, HIBERNATION_BIT, WATCHDOG_BIT};

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      DSCG_RUN = 3'b001,
      DSCG_SLEEP = 3'b010,
      DSCG_DEEP = 3'b100
   } dscg_mode_t;

   typedef struct packed {
      logic [11:0] addr;
      logic write;
      logic [31:0] wdata;
   } dscg_apb_req_t;

endpackage

// ### dscg_clock_gate.sv
// Deep-sleep clock gating register block with APB slave and unit access fault check
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Each gate bit at one clocks and enables its unit, at zero stops and disables it.
// - A bus access aimed at a unit whose clock is gated off is answered with a bus fault.
// - On reset the gating register reads 0x00000040, all gates off except hibernation.
// - The deep-sleep gating register governs only in deep-sleep; run and sleep use their own.
// - Sleep and deep-sleep gating apply only while the automatic gating bit is set.
// - Bit 16 gates converter module 0 in deep-sleep, read/write, reset zero.
// - Bit 6 gates the hibernation module in deep-sleep, read/write, reset one.
// - Bit 3 gates the watchdog module in deep-sleep, read/write, reset zero.
// - Bits 31:17, 15:7, 5:4 and 2:0 are read-only and read zero.
// - The register sits at offset 0x120 and is 32 bits wide.
module dscg_clock_gate (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_req,
   input wire logic deep_sleep_req,
   input wire logic [2:0] unit_access,
   output logic [2:0] unit_fault,
   output logic [2:0] unit_clk_en,
   output logic irq
);

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   dscg_pkg::dscg_apb_req_t req;
   logic wr_stb;
   logic rd_stb;
   logic hit;

   assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
   assign wr_stb = psel && penable && req.write;
   assign rd_stb = psel && penable && !req.write;
   assign pready = 1'b1;

   always_comb begin
      case (req.addr)
         dscg_pkg::DEEP_SLEEP_CLOCK_GATE_0_OFS,
         dscg_pkg::RUN_CLOCK_GATE_0_OFS,
         dscg_pkg::SLEEP_CLOCK_GATE_0_OFS,
         dscg_pkg::RUN_CLOCK_CONFIG_OFS,
         dscg_pkg::MODE_CTRL_OFS,
         dscg_pkg::IRQ_STATUS_OFS,
         dscg_pkg::IRQ_MASK_OFS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !hit;

   // ----------------------------------------
   // Gating registers
   // ----------------------------------------
   logic [31:0] deep_gate_q;
   logic [31:0] run_gate_q;
   logic [31:0] sleep_gate_q;
   logic [31:0] run_cfg_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         deep_gate_q <= dscg_pkg::GATE_RESET;
      end else if (wr_stb && req.addr == dscg_pkg::DEEP_SLEEP_CLOCK_GATE_0_OFS) begin
         deep_gate_q <= req.wdata & dscg_pkg::GATE_WRITABLE_MASK;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_gate_q <= dscg_pkg::GATE_RESET;
         sleep_gate_q <= dscg_pkg::GATE_RESET;
      end else if (wr_stb && req.addr == dscg_pkg::RUN_CLOCK_GATE_0_OFS) begin
         run_gate_q <= req.wdata & dscg_pkg::GATE_WRITABLE_MASK;
      end else if (wr_stb && req.addr == dscg_pkg::SLEEP_CLOCK_GATE_0_OFS) begin
         sleep_gate_q <= req.wdata & dscg_pkg::GATE_WRITABLE_MASK;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_cfg_q <= dscg_pkg::RUN_CONFIG_RESET;
      end else if (wr_stb && req.addr == dscg_pkg::RUN_CLOCK_CONFIG_OFS) begin
         run_cfg_q <= req.wdata & dscg_pkg::RUN_CONFIG_WRITABLE_MASK;
      end
   end

   // ----------------------------------------
   // Power mode
   // ----------------------------------------
   dscg_pkg::dscg_mode_t mode_q;
   dscg_pkg::dscg_mode_t mode_d;

   always_comb begin
      if (deep_sleep_req) begin
         mode_d = dscg_pkg::DSCG_DEEP;
      end else if (sleep_req) begin
         mode_d = dscg_pkg::DSCG_SLEEP;
      end else begin
         mode_d = dscg_pkg::DSCG_RUN;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_q <= dscg_pkg::DSCG_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------
   // Effective gating selection
   // ----------------------------------------
   logic auto_clock_gating;
   logic [31:0] active_gate;

   assign auto_clock_gating = run_cfg_q[dscg_pkg::AUTO_CLOCK_GATING_BIT];

   always_comb begin
      case (mode_q)
         dscg_pkg::DSCG_RUN: active_gate = run_gate_q;
         dscg_pkg::DSCG_SLEEP: active_gate = auto_clock_gating ? sleep_gate_q : run_gate_q;
         dscg_pkg::DSCG_DEEP: active_gate = auto_clock_gating ? deep_gate_q : run_gate_q;
         default: active_gate = run_gate_q;
      endcase
   end

   // ----------------------------------------
   // Per-unit enable and fault
   // ----------------------------------------
   logic [2:0] gate_d;
   logic [2:0] fault_q;

   for (genvar g = 0; g < dscg_pkg::NUM_GATES; g++) begin : g_gate
      assign gate_d[g] = active_gate[dscg_pkg::GATE_POS[g]];
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         unit_clk_en <= 3'h0;
      end else begin
         unit_clk_en <= gate_d;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fault_q <= 3'h0;
      end else begin
         fault_q <= unit_access & ~unit_clk_en;
      end
   end

   assign unit_fault = fault_q;

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   logic [2:0] irq_status_q;
   logic [2:0] irq_mask_q;
   logic [2:0] irq_clr;

   assign irq_clr = (wr_stb && req.addr == dscg_pkg::IRQ_STATUS_OFS) ? req.wdata[2:0] : 3'h0;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_status_q <= dscg_pkg::IRQ_RESET;
      end else begin
         irq_status_q <= (irq_status_q & ~irq_clr) | fault_q;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_mask_q <= dscg_pkg::IRQ_RESET;
      end else if (wr_stb && req.addr == dscg_pkg::IRQ_MASK_OFS) begin
         irq_mask_q <= req.wdata[2:0];
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [31:0] rdata_d;

   always_comb begin
      case (req.addr)
         dscg_pkg::DEEP_SLEEP_CLOCK_GATE_0_OFS: rdata_d = deep_gate_q;
         dscg_pkg::RUN_CLOCK_GATE_0_OFS: rdata_d = run_gate_q;
         dscg_pkg::SLEEP_CLOCK_GATE_0_OFS: rdata_d = sleep_gate_q;
         dscg_pkg::RUN_CLOCK_CONFIG_OFS: rdata_d = run_cfg_q;
         dscg_pkg::MODE_CTRL_OFS: rdata_d = {26'h0, unit_clk_en, mode_q};
         dscg_pkg::IRQ_STATUS_OFS: rdata_d = {29'h0, irq_status_q};
         dscg_pkg::IRQ_MASK_OFS: rdata_d = {29'h0, irq_mask_q};
         default: rdata_d = 32'h0;
      endcase
   end

   // Read data is registered at setup so it is stable through the access phase
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rdata_d;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_reset_value;
      @(posedge ref_clk) $fell(rst) |-> deep_gate_q == dscg_pkg::GATE_RESET;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("bad reset value");

   property p_reserved_zero;
      @(posedge ref_clk) disable iff (rst) (deep_gate_q & ~dscg_pkg::GATE_WRITABLE_MASK) == 32'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_write_takes;
      @(posedge ref_clk) disable iff (rst)
         wr_stb && paddr == dscg_pkg::DEEP_SLEEP_CLOCK_GATE_0_OFS |=>
            deep_gate_q == ($past(pwdata) & dscg_pkg::GATE_WRITABLE_MASK);
   endproperty
   a_write_takes: assert property (p_write_takes) else $error("write not stored");

   property p_deep_enable;
      @(posedge ref_clk) disable iff (rst)
         mode_q == dscg_pkg::DSCG_DEEP && auto_clock_gating |=>
            unit_clk_en == {$past(deep_gate_q[dscg_pkg::WATCHDOG_BIT]),
               $past(deep_gate_q[dscg_pkg::HIBERNATION_BIT]),
               $past(deep_gate_q[dscg_pkg::ADC0_BIT])};
   endproperty
   a_deep_enable: assert property (p_deep_enable) else $error("deep gating wrong");

   property p_sleep_enable;
      @(posedge ref_clk) disable iff (rst)
         !rst && mode_q == dscg_pkg::DSCG_SLEEP && auto_clock_gating |=>
            unit_clk_en == {$past(sleep_gate_q[dscg_pkg::WATCHDOG_BIT]),
               $past(sleep_gate_q[dscg_pkg::HIBERNATION_BIT]),
               $past(sleep_gate_q[dscg_pkg::ADC0_BIT])};
   endproperty
   a_sleep_enable: assert property (p_sleep_enable) else $error("sleep gating wrong");

   property p_run_enable;
      @(posedge ref_clk) disable iff (rst)
         !rst && mode_q == dscg_pkg::DSCG_RUN |=>
            unit_clk_en == {$past(run_gate_q[dscg_pkg::WATCHDOG_BIT]),
               $past(run_gate_q[dscg_pkg::HIBERNATION_BIT]),
               $past(run_gate_q[dscg_pkg::ADC0_BIT])};
   endproperty
   a_run_enable: assert property (p_run_enable) else $error("run gating wrong");

   property p_no_auto;
      @(posedge ref_clk) disable iff (rst)
         !rst && !auto_clock_gating |=>
            unit_clk_en == {$past(run_gate_q[dscg_pkg::WATCHDOG_BIT]),
               $past(run_gate_q[dscg_pkg::HIBERNATION_BIT]),
               $past(run_gate_q[dscg_pkg::ADC0_BIT])};
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("gating without auto bit");

   property p_fault;
      @(posedge ref_clk) disable iff (rst)
         (unit_access & ~unit_clk_en) != 3'h0 |=> unit_fault == $past(unit_access & ~unit_clk_en);
   endproperty
   a_fault: assert property (p_fault) else $error("missing bus fault");

   property p_irq_set;
      @(posedge ref_clk) disable iff (rst)
         fault_q != 3'h0 |=> (irq_status_q & $past(fault_q)) == $past(fault_q);
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("fault event lost");

   property p_read_gate;
      @(posedge ref_clk) disable iff (rst)
         psel && !penable && !pwrite && paddr == dscg_pkg::DEEP_SLEEP_CLOCK_GATE_0_OFS |=>
            prdata == $past(deep_gate_q);
   endproperty
   a_read_gate: assert property (p_read_gate) else $error("gate read data wrong");

   property p_no_fault;
      @(posedge ref_clk) disable iff (rst)
         (unit_access & ~unit_clk_en) == 3'h0 |=> unit_fault == 3'h0;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("spurious bus fault");

   property p_hib_default;
      @(posedge ref_clk) $fell(rst) ##0 (!wr_stb) [*2] |->
         deep_gate_q[dscg_pkg::HIBERNATION_BIT] && !deep_gate_q[dscg_pkg::WATCHDOG_BIT];
   endproperty
   a_hib_default: assert property (p_hib_default) else $error("gate defaults wrong");

   property p_adc_rw;
      @(posedge ref_clk) disable iff (rst)
         wr_stb && paddr == dscg_pkg::DEEP_SLEEP_CLOCK_GATE_0_OFS ##1 1'b1 |->
            deep_gate_q[dscg_pkg::ADC0_BIT] == $past(pwdata[dscg_pkg::ADC0_BIT]);
   endproperty
   a_adc_rw: assert property (p_adc_rw) else $error("adc gate not writable");

endmodule

// ### dscg_clock_gate_test.sv
// Testbench: APB register checks, gating per mode, unit faults and interrupt
`timescale 1ns/1ps
module dscg_clock_gate_test;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sleep_req = 1'b0;
   logic deep_sleep_req = 1'b0;
   logic [2:0] unit_access = 3'h0;
   logic [2:0] unit_fault;
   logic [2:0] unit_clk_en;
   logic irq;
   int bad_count = 0;
   int checked = 0;
   logic [31:0] rd;
   logic er;

   dscg_clock_gate i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
      .unit_access(unit_access), .unit_fault(unit_fault), .unit_clk_en(unit_clk_en),
      .irq(irq));

   always #20 ref_clk = ~ref_clk;

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // APB master
   // ----------------------------------------
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Write a gate register, let the enables follow, compare them
   task automatic gate(input logic [11:0] a, input logic [31:0] d, input logic [2:0] exp);
      apb(a, 1'b1, d);
      repeat (2) @(posedge ref_clk);
      #1;
      chk3(unit_clk_en, exp);
   endtask

   task automatic mode(input logic s, input logic ds);
      @(posedge ref_clk);
      sleep_req <= s;
      deep_sleep_req <= ds;
      repeat (3) @(posedge ref_clk);
   endtask

   initial begin
      #(40 * 5000);
      bad_count++;
      results();
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      // ----------------------------------------
      // Reset values and field access
      // ----------------------------------------
      apb(12'h120, 1'b0, 32'h0);
      chk32(rd, dscg_pkg::GATE_RESET);
      apb(12'h180, 1'b0, 32'h0);
      chk32(rd, 32'h0000_0011);
      apb(12'h120, 1'b1, 32'hffff_ffff);
      apb(12'h120, 1'b0, 32'h0);
      chk32(rd, dscg_pkg::GATE_WRITABLE_MASK);
      apb(12'h120, 1'b1, 32'h0000_0000);
      apb(12'h120, 1'b0, 32'h0);
      chk32(rd, 32'h0000_0000);
      apb(12'h0f0, 1'b1, 32'h0001_0048);
      chk3({2'b00, er}, 3'h1);
      apb(12'h120, 1'b0, 32'h0);
      chk32(rd, 32'h0000_0000);
      $display("test registers done");
      // ----------------------------------------
      // Gating by mode and gate bit
      // ----------------------------------------
      mode(1'b0, 1'b1);
      chk3(unit_clk_en, 3'b010);
      gate(12'h060, 32'h0800_0000, 3'b000);
      gate(12'h120, 32'h0001_0048, 3'b111);
      gate(12'h120, 32'h0001_0000, 3'b001);
      gate(12'h120, 32'h0000_0040, 3'b010);
      gate(12'h120, 32'h0000_0008, 3'b100);
      mode(1'b1, 1'b0);
      chk3(unit_clk_en, 3'b010);
      mode(1'b1, 1'b1);
      chk3(unit_clk_en, 3'b100);
      apb(12'h110, 1'b1, 32'h0001_0000);
      mode(1'b1, 1'b0);
      chk3(unit_clk_en, 3'b001);
      mode(1'b0, 1'b0);
      chk3(unit_clk_en, 3'b010);
      mode(1'b1, 1'b1);
      chk3(unit_clk_en, 3'b100);
      $display("test gating done");
      // ----------------------------------------
      // Faults on gated units and interrupt
      // ----------------------------------------
      @(posedge ref_clk);
      unit_access <= 3'b111;
      @(posedge ref_clk);
      unit_access <= 3'b000;
      #1;
      chk3(unit_fault, 3'b011);
      repeat (2) @(posedge ref_clk);
      #1;
      chk3({2'b00, irq}, 3'h0);
      apb(12'h184, 1'b0, 32'h0);
      chk32(rd, 32'h0000_0003);
      apb(12'h188, 1'b1, 32'h0000_0007);
      #1;
      chk3({2'b00, irq}, 3'h1);
      apb(12'h184, 1'b1, 32'h0000_0003);
      #1;
      chk3({2'b00, irq}, 3'h0);
      $display("test faults done");
      // ----------------------------------------
      // Reset in mid-run
      // ----------------------------------------
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk3(unit_clk_en, 3'b010);
      chk3({2'b00, irq}, 3'h0);
      apb(12'h120, 1'b0, 32'h0);
      chk32(rd, dscg_pkg::GATE_RESET);
      apb(12'h060, 1'b0, 32'h0);
      chk32(rd, 32'h0000_0000);
      $display("test reset done");
      results();
   end
endmodule
